/* File: rtl/cal_menu_ctrl.sv */
// Calibration menu controller: entry, menu stepping, digit editing, commit
// Functional notes
// RQ1: Closed rear link enters calibration
// RQ2: Display-then-total held six seconds enters calibration
// RQ3: Two-key entry ignored when access disabled
// RQ4: Access setting: front allowed or forbidden
// RQ5: Rate key moves cursor to next digit
// RQ6: Total key increments digit or choice
// RQ7: Reset key zeroes flashing digit
// RQ8: Display key advances menu step
// RQ9: Title shown first, then flashing value
// RQ10: Key lamps lit only for useful keys
// RQ11: Four top choices, total cycles, display selects
// RQ12: Display at end choice exits calibration; code exits only while the rear link is open
// RQ13: Power loss discards session edits
// RQ14: Edits committed only on normal exit
// RQ15: Reset at total-clear clears both totals
// RQ16: Input type: pulse, coil, third sensor
// RQ17: Debounce on cuts above 1kHz
// RQ18: Rate decimals zero to five
// RQ19: Timebase second, minute, hour, day
// RQ20: Filter constant one to twenty
// RQ21: Total divisor 0.02 to 2000
// RQ22: Total decimals zero to three each
// RQ23: Pulse width choice, longest 100ms
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module cal_menu_ctrl
  import cal_menu_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Front panel and rear link
  input wire logic [3:0] KEYS,
  input wire logic CAL_LINK,
  output logic [3:0] KEY_LAMPS,
  output logic SHOW_VALUE,
  output logic FLASH,
  output logic [3:0] STEP,
  output logic [2:0] CURSOR,
  output logic [31:0] SHOW_DATA,
  // Mode and totals
  output logic CAL_MODE,
  output logic CLEAR_TOTALS,
  output logic DEBOUNCE_ON
);

  // ----------------------------------------
  // Parameter store
  // ----------------------------------------
  // Packed word 0: input type, debounce, rate decimals, timebase, filter
  // Packed word 1: resettable, accumulated decimals, pulse, access
  logic [1:0] input_type_step, nv_input;
  logic debounce_setting, nv_debounce;
  logic [2:0] rate_decimals, nv_rdec;
  logic [1:0] rate_timebase, nv_tbase;
  logic [4:0] filter_const, nv_filter;
  logic [31:0] total_unit_divisor, nv_div;
  logic [1:0] resettable_decimals, nv_tdec;
  logic [1:0] accumulated_decimals, nv_adec;
  logic [1:0] pulse_choice, nv_pulse;
  logic front_access, nv_access;

  logic in_cal;
  step_e step;
  top_choice_e top_choice;
  logic show_val;
  logic [2:0] cursor;
  logic [3:0] press;
  logic hold_done;
  logic link_q;
  logic total_clear_pulse;

  key_press_detect u_keys (
    .clk(CLK),
    .reset(RESET),
    .keys(KEYS),
    .hold_enable(front_access & ~in_cal), // [RQ3]
    .press(press),
    .hold_done(hold_done) // [RQ2]
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] bcd_inc(input logic [31:0] v, input logic [2:0] d);
    logic [3:0] nib;
    logic [31:0] r;
    nib = v[d*4 +: 4];
    r = v;
    r[d*4 +: 4] = (nib >= DIGIT_MAX) ? 4'h0 : nib + 4'h1;
    return r;
  endfunction : bcd_inc

  function automatic logic [31:0] bcd_zero(input logic [31:0] v, input logic [2:0] d);
    logic [31:0] r;
    r = v;
    r[d*4 +: 4] = 4'h0;
    return r;
  endfunction : bcd_zero

  function automatic logic [31:0] div_clamp(input logic [31:0] v);
    logic [31:0] r;
    r = v;
    if (v < DIV_MIN) r = DIV_MIN; // [RQ21]
    if (v > DIV_MAX) r = DIV_MAX; // [RQ21]
    return r;
  endfunction : div_clamp

  function automatic logic is_numeric(input step_e s);
    return (s == ST_DIV);
  endfunction : is_numeric

  function automatic logic is_editable(input step_e s);
    return !(s == ST_TOP || s == ST_END);
  endfunction : is_editable

  // ----------------------------------------
  // Entry and exit
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      link_q <= 1'b0;
    end else begin
      link_q <= CAL_LINK;
    end
  end

  logic exit_now;
  assign exit_now = in_cal && press[KEY_DISPLAY] && show_val &&
                    ((step == ST_END) || (step == ST_TOP && top_choice == TOP_EXIT));

  always_ff @(posedge CLK) begin
    if (RESET) begin
      in_cal <= 1'b0;
    end else if (!in_cal) begin
      if (link_q || hold_done) begin // [RQ1] [RQ2]
        in_cal <= 1'b1;
      end
    end else if (exit_now && !CAL_LINK) begin // [RQ12]
      in_cal <= 1'b0;
    end
  end

  // ----------------------------------------
  // Menu stepping
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET || !in_cal) begin
      step <= ST_TOP;
      top_choice <= TOP_SETUP;
      show_val <= 1'b0;
      cursor <= 3'h0;
    end else if (press[KEY_DISPLAY]) begin
      cursor <= 3'h0;
      if (!show_val) begin
        show_val <= 1'b1; // [RQ9]
      end else begin
        show_val <= 1'b0; // [RQ8]
        case (step)
          ST_TOP: begin
            if (top_choice == TOP_SETUP) begin // [RQ11]
              step <= ST_TOTCLR;
            end else if (top_choice != TOP_EXIT) begin
              step <= ST_END;
            end
          end
          ST_ACCESS: step <= ST_END;
          ST_END: step <= ST_TOP;
          default: step <= step_e'(step + 4'h1);
        endcase
      end
    end else if (show_val && step == ST_TOP && press[KEY_TOTAL]) begin
      top_choice <= top_choice_e'(top_choice + 2'h1); // [RQ11]
    end else if (show_val && is_numeric(step) && press[KEY_RATE]) begin
      cursor <= (cursor == 3'(DIGITS + 1)) ? 3'h0 : cursor + 3'h1; // [RQ5]
    end
  end

  // ----------------------------------------
  // Working copy edits
  // ----------------------------------------
  logic ed_tot, ed_rst;
  assign ed_tot = in_cal && show_val && press[KEY_TOTAL]; // [RQ6]
  assign ed_rst = in_cal && show_val && press[KEY_RESET]; // [RQ7]

  always_ff @(posedge CLK) begin
    if (RESET || !in_cal) begin
      // Reload from store; power loss also lands here [RQ13]
      input_type_step <= nv_input;
      debounce_setting <= nv_debounce;
      rate_decimals <= nv_rdec;
      rate_timebase <= nv_tbase;
      filter_const <= nv_filter;
      total_unit_divisor <= nv_div;
      resettable_decimals <= nv_tdec;
      accumulated_decimals <= nv_adec;
      pulse_choice <= nv_pulse;
      front_access <= nv_access;
    end else if (ed_tot) begin
      case (step)
        ST_INPUT: input_type_step <= (input_type_step == INPUT_TYPES - 2'h1) ? 2'h0 :
                                     input_type_step + 2'h1; // [RQ16]
        ST_DEBOUNCE: debounce_setting <= ~debounce_setting; // [RQ17]
        ST_RDEC: rate_decimals <= (rate_decimals == RATE_DEC_MAX) ? 3'h0 :
                                  rate_decimals + 3'h1; // [RQ18]
        ST_TBASE: rate_timebase <= rate_timebase + 2'h1; // [RQ19]
        ST_FILTER: filter_const <= (filter_const == FILTER_MAX) ? FILTER_MIN :
                                   filter_const + 5'h01; // [RQ20]
        ST_DIV: total_unit_divisor <= div_clamp(bcd_inc(total_unit_divisor, cursor));
        ST_TDEC: resettable_decimals <= (resettable_decimals == TOT_DEC_MAX) ? 2'h0 :
                                        resettable_decimals + 2'h1; // [RQ22]
        ST_ADEC: accumulated_decimals <= (accumulated_decimals == TOT_DEC_MAX) ? 2'h0 :
                                         accumulated_decimals + 2'h1; // [RQ22]
        ST_PULSE: pulse_choice <= (pulse_choice == PULSE_CHOICES) ? 2'h0 :
                                  pulse_choice + 2'h1; // [RQ23]
        ST_ACCESS: front_access <= ~front_access; // [RQ4]
        default: ;
      endcase
    end else if (ed_rst && step == ST_DIV) begin
      total_unit_divisor <= div_clamp(bcd_zero(total_unit_divisor, cursor)); // [RQ7]
    end
  end

  // ----------------------------------------
  // Non-volatile store, committed on exit
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      nv_input <= 2'h0;
      nv_debounce <= 1'b0;
      nv_rdec <= 3'h0;
      nv_tbase <= 2'h0;
      nv_filter <= FILTER_MIN;
      nv_div <= DIV_ONE;
      nv_tdec <= 2'h0;
      nv_adec <= 2'h0;
      nv_pulse <= 2'h0;
      nv_access <= 1'b1;
    end else if (exit_now && !CAL_LINK) begin // [RQ14]
      nv_input <= input_type_step;
      nv_debounce <= debounce_setting;
      nv_rdec <= rate_decimals;
      nv_tbase <= rate_timebase;
      nv_filter <= filter_const;
      nv_div <= total_unit_divisor;
      nv_tdec <= resettable_decimals;
      nv_adec <= accumulated_decimals;
      nv_pulse <= pulse_choice;
      nv_access <= front_access;
    end
  end

  // ----------------------------------------
  // Panel outputs
  // ----------------------------------------
  assign total_clear_pulse = ed_rst && step == ST_TOTCLR;

  logic [31:0] next_show;
  always_comb begin
    case (step)
      ST_TOP: next_show = {30'h0, top_choice};
      ST_INPUT: next_show = {30'h0, input_type_step};
      ST_DEBOUNCE: next_show = {31'h0, debounce_setting};
      ST_RDEC: next_show = {29'h0, rate_decimals};
      ST_TBASE: next_show = {30'h0, rate_timebase};
      ST_FILTER: next_show = {27'h0, filter_const};
      ST_DIV: next_show = total_unit_divisor;
      ST_TDEC: next_show = {30'h0, resettable_decimals};
      ST_ADEC: next_show = {30'h0, accumulated_decimals};
      ST_PULSE: next_show = {30'h0, pulse_choice};
      ST_ACCESS: next_show = {31'h0, front_access};
      default: next_show = 32'h0;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      KEY_LAMPS <= 4'h0;
      SHOW_VALUE <= 1'b0;
      FLASH <= 1'b0;
      STEP <= 4'h0;
      CURSOR <= 3'h0;
      SHOW_DATA <= 32'h0;
      CAL_MODE <= 1'b0;
      CLEAR_TOTALS <= 1'b0;
      DEBOUNCE_ON <= 1'b0;
    end else begin
      SHOW_VALUE <= in_cal && show_val; // [RQ9]
      FLASH <= in_cal && show_val && is_editable(step); // [RQ9]
      KEY_LAMPS[KEY_DISPLAY] <= 1'b0; // [RQ10]
      KEY_LAMPS[KEY_TOTAL] <= in_cal && show_val && step != ST_TOTCLR &&
                              step != ST_END; // [RQ10]
      KEY_LAMPS[KEY_RATE] <= in_cal && show_val && is_numeric(step); // [RQ10]
      KEY_LAMPS[KEY_RESET] <= in_cal && show_val &&
                              (is_numeric(step) || step == ST_TOTCLR); // [RQ10]
      STEP <= step;
      CURSOR <= cursor;
      SHOW_DATA <= next_show;
      CAL_MODE <= in_cal;
      CLEAR_TOTALS <= total_clear_pulse; // [RQ15]
      DEBOUNCE_ON <= nv_debounce; // [RQ17]
    end
  end

  // ----------------------------------------
  // APB slave, zero wait, read only
  // ----------------------------------------
  logic [31:0] next_prdata;
  always_comb begin
    case (PADDR)
      REG_STATUS: next_prdata = {20'h0, cursor, show_val, step, 3'h0, in_cal};
      REG_KEYS: next_prdata = {28'h0, KEYS};
      REG_VALUE: next_prdata = next_show;
      REG_ACTIVE0: next_prdata = {19'h0, filter_const, rate_timebase, rate_decimals,
                                  debounce_setting, input_type_step};
      REG_ACTIVE1: next_prdata = {25'h0, front_access, pulse_choice,
                                  accumulated_decimals, resettable_decimals};
      REG_ACTIVE_DIV: next_prdata = total_unit_divisor;
      REG_STORED0: next_prdata = {19'h0, nv_filter, nv_tbase, nv_rdec, nv_debounce,
                                  nv_input};
      REG_STORED1: next_prdata = {25'h0, nv_access, nv_pulse, nv_adec, nv_tdec};
      REG_STORED_DIV: next_prdata = nv_div;
      default: next_prdata = 32'h0;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      PRDATA <= 32'h0;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= next_prdata;
    end
  end

  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && PWRITE;

endmodule : cal_menu_ctrl

/* File: rtl/cal_menu_pkg.sv */
// Constants, encodings and register map for the calibration menu controller
package cal_menu_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int HOLD_TIME_MS = 6000;
  localparam longint HOLD_CYCLES_L = longint'(HOLD_TIME_MS) * 1000 * CLK_MHZ;
  localparam int HOLD_CYCLES = int'(HOLD_CYCLES_L);
  localparam int DEBOUNCE_CUTOFF_HZ = 1000;

  // ----------------------------------------
  // APB register offsets
  // ----------------------------------------
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_KEYS = 8'h04;
  localparam logic [7:0] REG_VALUE = 8'h08;
  localparam logic [7:0] REG_ACTIVE0 = 8'h0C;
  localparam logic [7:0] REG_ACTIVE1 = 8'h10;
  localparam logic [7:0] REG_ACTIVE_DIV = 8'h14;
  localparam logic [7:0] REG_STORED0 = 8'h18;
  localparam logic [7:0] REG_STORED1 = 8'h1C;
  localparam logic [7:0] REG_STORED_DIV = 8'h20;

  // ----------------------------------------
  // Key bit positions
  // ----------------------------------------
  localparam int KEY_RATE = 0;
  localparam int KEY_TOTAL = 1;
  localparam int KEY_RESET = 2;
  localparam int KEY_DISPLAY = 3;

  // ----------------------------------------
  // Value limits and reset values
  // ----------------------------------------
  localparam int DIGITS = 6;
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  localparam logic [2:0] RATE_DEC_MAX = 3'h5;
  localparam logic [1:0] TOT_DEC_MAX = 2'h3;
  localparam logic [1:0] INPUT_TYPES = 2'h3;
  localparam logic [1:0] TIMEBASES = 2'h3;
  localparam logic [4:0] FILTER_MIN = 5'h01;
  localparam logic [4:0] FILTER_MAX = 5'h14;
  localparam logic [1:0] PULSE_CHOICES = 2'h2;
  // Divisor held as BCD with four decimals: 0.0200 .. 2000.0000
  localparam logic [31:0] DIV_MIN = 32'h0000_0200;
  localparam logic [31:0] DIV_MAX = 32'h2000_0000;
  localparam logic [31:0] DIV_ONE = 32'h0001_0000;

  typedef enum logic [1:0] {TOP_SETUP, TOP_COMMS, TOP_TEST, TOP_EXIT} top_choice_e;
  typedef enum logic [3:0] {
    ST_TOP, ST_TOTCLR, ST_INPUT, ST_DEBOUNCE, ST_RDEC, ST_TBASE, ST_FILTER,
    ST_DIV, ST_TDEC, ST_ADEC, ST_PULSE, ST_ACCESS, ST_END
  } step_e;

endpackage : cal_menu_pkg

/* File: rtl/key_press_detect.sv */
// Key press edge detector and two-key hold timer
`timescale 1ns/1ps
module key_press_detect
  import cal_menu_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Keys
  input wire logic [3:0] keys,
  input wire logic hold_enable,
  // Results
  output logic [3:0] press,
  output logic hold_done
);

  logic [3:0] keys_q;
  logic [31:0] hold_cnt;
  logic armed;

  always_ff @(posedge clk) begin
    if (reset) begin
      keys_q <= 4'h0;
    end else begin
      keys_q <= keys;
    end
  end

  assign press = keys & ~keys_q;

  // Display must be down before total arrives
  always_ff @(posedge clk) begin
    if (reset) begin
      armed <= 1'b0;
    end else if (!keys[KEY_DISPLAY]) begin
      armed <= 1'b0;
    end else if (!keys_q[KEY_DISPLAY] || !keys[KEY_TOTAL]) begin
      armed <= !keys[KEY_TOTAL];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      hold_cnt <= 32'h0;
      hold_done <= 1'b0;
    end else if (hold_enable && armed && keys[KEY_DISPLAY] && keys[KEY_TOTAL]) begin
      if (hold_cnt == 32'(HOLD_CYCLES - 1)) begin
        hold_done <= 1'b1;
      end else begin
        hold_cnt <= hold_cnt + 32'h1;
      end
    end else begin
      hold_cnt <= 32'h0;
      hold_done <= 1'b0;
    end
  end

endmodule : key_press_detect

/* File: bench/cal_menu_ctrl_props.sv */
// Concurrent checks on the calibration menu controller ports
`timescale 1ns/1ps
module cal_menu_ctrl_props
  import cal_menu_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Panel and mode
  input wire logic CAL_LINK,
  input wire logic CAL_MODE,
  input wire logic CLEAR_TOTALS,
  input wire logic SHOW_VALUE,
  input wire logic FLASH,
  input wire logic [3:0] STEP,
  input wire logic [3:0] KEY_LAMPS
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence s_link_rise;
    $rose(CAL_LINK) && !CAL_MODE;
  endsequence
  sequence s_enter;
    ##[1:3] CAL_MODE;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_link_entry: assert property (s_link_rise |-> s_enter)
    else $error("link closure did not enter calibration");
  a_link_holds: assert property (CAL_MODE && CAL_LINK |=> CAL_MODE)
    else $error("calibration left while link closed");
  a_clear_pulse: assert property (CLEAR_TOTALS |=> !CLEAR_TOTALS)
    else $error("total clear longer than one cycle");
  a_clear_step: assert property (CLEAR_TOTALS |-> CAL_MODE && STEP == 4'h1)
    else $error("total clear outside its step");
  a_flash_value: assert property (FLASH |-> SHOW_VALUE)
    else $error("title shown flashing");
  a_title_first: assert property (CAL_MODE && $past(CAL_MODE) && STEP != $past(STEP)
    |-> !SHOW_VALUE)
    else $error("new step did not start with title");
  a_lamps_title: assert property (!SHOW_VALUE && $past(!SHOW_VALUE)
    |-> KEY_LAMPS == 4'h0)
    else $error("key lamps lit while no value shown");
  a_write_err: assert property (PSEL && PENABLE && PWRITE |-> PSLVERR)
    else $error("write not refused");
  a_read_ok: assert property (PSEL && PENABLE && !PWRITE |-> PREADY && !PSLVERR)
    else $error("read refused");
endmodule : cal_menu_ctrl_props

bind cal_menu_ctrl cal_menu_ctrl_props u_props (.CLK(CLK), .RESET(RESET), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .CAL_LINK(CAL_LINK), .CAL_MODE(CAL_MODE), .CLEAR_TOTALS(CLEAR_TOTALS),
  .SHOW_VALUE(SHOW_VALUE), .FLASH(FLASH), .STEP(STEP), .KEY_LAMPS(KEY_LAMPS));

/* File: bench/panel_operator.sv */
// Operator model: presses one front key at a time and works the rear link
`timescale 1ns/1ps
module panel_operator (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Commands
  input wire logic go,
  input wire logic [1:0] sel,
  input wire logic link_in,
  // Panel side
  output logic [3:0] keys,
  output logic cal_link,
  output logic busy
);
  logic [3:0] cnt;
  always_ff @(posedge clk) begin
    if (reset) begin
      keys <= 4'h0;
      busy <= 1'b0;
      cnt <= 4'h0;
    end else if (go && !busy) begin
      busy <= 1'b1;
      cnt <= 4'h0;
      keys <= 4'h1 << sel;
    end else if (busy) begin
      cnt <= cnt + 4'h1;
      if (cnt == 4'h3) keys <= 4'h0;
      if (cnt == 4'h8) busy <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    cal_link <= reset ? 1'b0 : link_in;
  end
endmodule : panel_operator

/* File: bench/cal_menu_ctrl_tb.sv */
// Testbench for the calibration menu controller
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module cal_menu_ctrl_tb;
  import cal_menu_pkg::*;
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, go = 0, link_in = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, show_data, rd;
  logic pready, pslverr, cal_link, cal_mode, clear_totals, show_value, flash, deb_on, busy;
  logic [3:0] keys, lamps, step;
  logic [2:0] cursor;
  logic [1:0] sel = 2'h0;
  int num_errors = 0, n_compared = 0, n_clear = 0;
  initial forever #2 clk = ~clk;
  always @(posedge clk) if (clear_totals === 1'b1) n_clear++;
  cal_menu_ctrl uut (.CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .KEYS(keys), .CAL_LINK(cal_link), .KEY_LAMPS(lamps),
    .SHOW_VALUE(show_value), .FLASH(flash), .STEP(step), .CURSOR(cursor),
    .SHOW_DATA(show_data), .CAL_MODE(cal_mode), .CLEAR_TOTALS(clear_totals),
    .DEBOUNCE_ON(deb_on));
  panel_operator op (.clk(clk), .reset(reset), .go(go), .sel(sel), .link_in(link_in),
    .keys(keys), .cal_link(cal_link), .busy(busy));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task stop_test;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  task apb(input logic wr, input logic [7:0] a, output logic [31:0] d, output logic err);
    int i;
    i = 0;
    @(posedge clk) begin psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; end
    @(posedge clk) penable <= 1;
    do begin @(posedge clk); i++; end while (pready !== 1'b1 && i < 20);
    d = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (pready !== 1'b1) begin num_errors++; stop_test(); end
  endtask : apb
  task rdchk(input logic [7:0] a, input logic [31:0] ex);
    logic e;
    apb(1'b0, a, rd, e);
    `CHK("read", ex, rd)
  endtask : rdchk
  task press(input int k, input int n);
    int i;
    repeat (n) begin
      i = 0;
      @(posedge clk) begin go <= 1; sel <= 2'(k); end
      @(posedge clk) go <= 0;
      do begin @(negedge clk); i++; end while (busy !== 1'b0 && i < 40);
      if (busy !== 1'b0) begin num_errors++; stop_test(); end
    end
  endtask : press
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    logic e;
    repeat (3) @(posedge clk);
    reset <= 0;
    rdchk(REG_STORED0, 32'h0000_0100);
    rdchk(REG_STORED1, 32'h0000_0040);
    rdchk(REG_STORED_DIV, DIV_ONE);
    rdchk(8'h30, 32'h0);
    apb(1'b1, REG_STATUS, rd, e);
    `CHK("write refused", 1'b1, e)
    `CHK("idle mode", 1'b0, cal_mode)
    link_in <= 1;
    repeat (6) @(negedge clk);
    `CHK("link entry", 1'b1, cal_mode)
    `CHK("top title", 1'b0, show_value)
    press(KEY_DISPLAY, 2);
    `CHK("setup step", 4'h1, step)
    press(KEY_DISPLAY, 1);
    `CHK("reset lamp", 1'b1, lamps[KEY_RESET])
    `CHK("display lamp", 1'b0, lamps[KEY_DISPLAY])
    press(KEY_RESET, 1);
    `CHK("clear pulses", 1, n_clear)
    press(KEY_DISPLAY, 2);
    press(KEY_TOTAL, 1);
    rdchk(REG_ACTIVE0, 32'h0000_0101);
    press(KEY_DISPLAY, 2);
    press(KEY_TOTAL, 1);
    `CHK("debounce not yet applied", 1'b0, deb_on)
    press(KEY_DISPLAY, 8);
    `CHK("divisor step", 4'h7, step)
    `CHK("value flash", 1'b1, flash)
    press(KEY_TOTAL, 1);
    press(KEY_RATE, 1);
    `CHK("cursor", 3'h1, cursor)
    press(KEY_TOTAL, 1);
    rdchk(REG_ACTIVE_DIV, 32'h0001_0011);
    press(KEY_RESET, 1);
    rdchk(REG_ACTIVE_DIV, 32'h0001_0001);
    `CHK("shown divisor", 32'h0001_0001, show_data)
    press(KEY_DISPLAY, 8);
    `CHK("access step", 4'hB, step)
    press(KEY_TOTAL, 1);
    rdchk(REG_STORED1, 32'h0000_0040);
    press(KEY_DISPLAY, 2);
    `CHK("end step", 4'hC, step)
    link_in <= 0;
    press(KEY_DISPLAY, 1);
    `CHK("normal exit", 1'b0, cal_mode)
    rdchk(REG_STORED0, 32'h0000_0105);
    `CHK("debounce applied", 1'b1, deb_on)
    rdchk(REG_STORED1, 32'h0000_0000);
    rdchk(REG_STORED_DIV, 32'h0001_0001);
    link_in <= 1;
    repeat (6) @(negedge clk);
    link_in <= 0;
    press(KEY_DISPLAY, 1);
    press(KEY_TOTAL, 3);
    press(KEY_DISPLAY, 1);
    `CHK("top exit", 1'b0, cal_mode)
    link_in <= 1;
    repeat (6) @(negedge clk);
    link_in <= 0;
    press(KEY_DISPLAY, 5);
    press(KEY_TOTAL, 1);
    @(posedge clk) reset <= 1;
    repeat (3) @(posedge clk);
    reset <= 0;
    rdchk(REG_ACTIVE0, 32'h0000_0100);
    `CHK("reset leaves cal", 1'b0, cal_mode)
    stop_test();
  end
endmodule : cal_menu_ctrl_tb
